// ### hdl/isf_top.sv
// Purpose: gathers ten interrupt sources into request flags and lines
// Assumes: pins asynchronous; peripheral events one-cycle pulses on mclk
// Notes: core acknowledges the selected source with a one-cycle vector pulse
`timescale 1ns/1ps
// Summary of operation
// - ten sources: pins, timers, serial, ddc, usb
// - ext a level or edge by trigger bit
// - edge requests cleared when core vectors
// - level flag follows pin, not cleared when interrupt taken
// - ext b level or edge by trigger bit
// - adc completion may drive ext b
// - timers zero/one overflow set flags, timer zero not in mode 3
// - timer zero/one flags cleared on service
// - timer two overflow flag software cleared only
// - timer_two_ext_input edge, gated by enable, sets ext flag
// - two-wire flag cleared by hardware on service
// - ddc irq from three flags
// - only ddc2b flag hardware cleared
// - usb events set usb flags
// - usb flags stay until software clears
// - per-source enables plus global enable
// - fixed polling order picks among equals
module isf_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic ext_irq_a_trigger_type,
    input wire logic ext_irq_b_trigger_type,
    input wire logic adc_owns_ext_b,
    input wire logic adc_done,
    input wire logic [1:0] timer_zero_mode,
    input wire logic timer_zero_overflow,
    input wire logic timer_one_overflow,
    input wire logic timer_two_overflow,
    input wire logic timer_two_ext_input,
    input wire logic timer_two_ext_enable,
    input wire logic timer_two_sw_clear,
    input wire logic twowire_event,
    input wire logic ddc2b_event,
    input wire logic ddc1_event,
    input wire logic protocol_switch_event,
    input wire logic ddc_sw_clear,
    input wire logic [6:0] usb_events,
    input wire logic [6:0] usb_sw_clear,
    input wire logic uart_a_req,
    input wire logic uart_b_req,
    input wire logic [9:0] src_enable,
    input wire logic global_irq_enable,
    input wire logic core_vector,
    output logic ext_irq_a_flag,
    output logic ext_irq_b_flag,
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag,
    output logic timer_two_overflow_flag,
    output logic timer_two_ext_flag,
    output logic serial_ctrl_irq_flag,
    output logic ddc2b_flag,
    output logic ddc1_flag,
    output logic protocol_switch_flag,
    output logic [6:0] usb_flags,
    output logic [9:0] src_req,
    output logic irq_req,
    output logic [3:0] irq_sel
);
    isf_pkg::isf_state_s_t s_q;
    isf_pkg::isf_state_s_t s_d;
    logic [isf_pkg::NUM_SRC-1:0] req_now;
    logic [isf_pkg::NUM_SRC-1:0] req_gated;
    logic [isf_pkg::NUM_SRC-1:0] ack;
    logic b_in;
    logic a_edge;
    logic b_edge;
    logic t2_edge;

    // ************************************************************
    // flag update
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.sync_a = {s_q.sync_a[0], ext_irq_a_pin};
        s_d.sync_b = {s_q.sync_b[0], ext_irq_b_pin};
        s_d.sync_timer_two_ext_input = {s_q.sync_timer_two_ext_input[0], timer_two_ext_input};
        // adc takes the ext b input when it owns it
        b_in = adc_owns_ext_b ? adc_done : s_q.sync_b[1];
        s_d.ext_a_prev = s_q.sync_a[1];
        s_d.ext_b_prev = b_in;
        s_d.timer_two_ext_input_prev = s_q.sync_timer_two_ext_input[1];
        // pins active low, as usual for external requests
        a_edge = s_q.ext_a_prev & ~s_q.sync_a[1];
        b_edge = s_q.ext_b_prev & ~b_in;
        t2_edge = s_q.timer_two_ext_input_prev & ~s_q.sync_timer_two_ext_input[1];
        ack = '0;
        if (core_vector && s_q.irq_req && s_q.state == isf_pkg::ISF_IDLE) begin
            ack[s_q.irq_sel] = 1'b1;
        end
        // ext a
        if (ext_irq_a_trigger_type) begin
            if (a_edge) begin
                s_d.ext_irq_a_flag = 1'b1;
            end else if (ack[isf_pkg::SRC_EXT_A]) begin
                s_d.ext_irq_a_flag = 1'b0;
            end
        end else begin
            // level flag follows pin; held while pin low, not cleared when taken
            s_d.ext_irq_a_flag = ~s_q.sync_a[1];
        end
        if (ext_irq_b_trigger_type) begin
            if (b_edge) begin
                s_d.ext_irq_b_flag = 1'b1;
            end else if (ack[isf_pkg::SRC_EXT_B]) begin
                s_d.ext_irq_b_flag = 1'b0;
            end
        end else begin
            s_d.ext_irq_b_flag = ~b_in;
        end
        // timers: set wins over hardware clear
        if (timer_zero_overflow && timer_zero_mode != isf_pkg::TMR0_MODE_SPLIT)
        begin
            s_d.timer_zero_overflow_flag = 1'b1;
        end else if (ack[isf_pkg::SRC_TMR0]) begin
            s_d.timer_zero_overflow_flag = 1'b0;
        end
        if (timer_one_overflow) begin
            s_d.timer_one_overflow_flag = 1'b1;
        end else if (ack[isf_pkg::SRC_TMR1]) begin
            s_d.timer_one_overflow_flag = 1'b0;
        end
        if (timer_two_overflow) begin
            s_d.timer_two_overflow_flag = 1'b1;
        end else if (timer_two_sw_clear) begin
            s_d.timer_two_overflow_flag = 1'b0;
        end
        if (t2_edge && timer_two_ext_enable) begin
            s_d.timer_two_ext_flag = 1'b1;
        end else if (timer_two_sw_clear) begin
            s_d.timer_two_ext_flag = 1'b0;
        end
        if (twowire_event) begin
            s_d.serial_ctrl_irq_flag = 1'b1;
        end else if (ack[isf_pkg::SRC_TWI]) begin
            s_d.serial_ctrl_irq_flag = 1'b0;
        end
        if (ddc2b_event) begin
            s_d.ddc2b_flag = 1'b1;
        end else if (ack[isf_pkg::SRC_DDC]) begin
            s_d.ddc2b_flag = 1'b0;
        end
        if (ddc1_event) begin
            s_d.ddc1_flag = 1'b1;
        end else if (ddc_sw_clear) begin
            s_d.ddc1_flag = 1'b0;
        end
        if (protocol_switch_event) begin
            s_d.protocol_switch_flag = 1'b1;
        end else if (ddc_sw_clear) begin
            s_d.protocol_switch_flag = 1'b0;
        end
        // usb: event wins over software clear per bit
        s_d.usb_flags = (s_q.usb_flags & ~usb_sw_clear) | usb_events;
        // ************************************************************
        // request lines and polling
        // ************************************************************
        req_now = '0;
        req_now[isf_pkg::SRC_EXT_A] = s_d.ext_irq_a_flag;
        req_now[isf_pkg::SRC_UART_B] = uart_b_req;
        req_now[isf_pkg::SRC_TMR0] = s_d.timer_zero_overflow_flag;
        req_now[isf_pkg::SRC_TWI] = s_d.serial_ctrl_irq_flag;
        req_now[isf_pkg::SRC_EXT_B] = s_d.ext_irq_b_flag;
        req_now[isf_pkg::SRC_DDC] = s_d.ddc2b_flag | s_d.ddc1_flag |
            s_d.protocol_switch_flag;
        req_now[isf_pkg::SRC_TMR1] = s_d.timer_one_overflow_flag;
        req_now[isf_pkg::SRC_USB] = |s_d.usb_flags;
        req_now[isf_pkg::SRC_UART_A] = uart_a_req;
        req_now[isf_pkg::SRC_TMR2] = s_d.timer_two_overflow_flag |
            s_d.timer_two_ext_flag;
        s_d.src_req = req_now;
        req_gated = req_now & src_enable & {isf_pkg::NUM_SRC{global_irq_enable}};
        s_d.irq_req = |req_gated;
        s_d.irq_sel = isf_pkg::SRC_NONE;
        for (int i = isf_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req_gated[i]) begin
                s_d.irq_sel = 4'(i);
            end
        end
        // one acknowledge per vector pulse; next one after a gap cycle
        case (s_q.state)
            isf_pkg::ISF_IDLE: begin
                if (|ack) begin
                    s_d.state = isf_pkg::ISF_ACK;
                    s_d.irq_req = 1'b0;
                    s_d.irq_sel = isf_pkg::SRC_NONE;
                end
            end
            isf_pkg::ISF_ACK: begin
                s_d.state = isf_pkg::ISF_IDLE;
            end
            default: begin
                s_d.state = isf_pkg::ISF_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
            s_q.sync_a <= 2'h3;
            s_q.sync_b <= 2'h3;
            s_q.sync_timer_two_ext_input <= 2'h3;
            s_q.ext_a_prev <= 1'b1;
            s_q.ext_b_prev <= 1'b1;
            s_q.timer_two_ext_input_prev <= 1'b1;
            s_q.usb_flags <= isf_pkg::USB_FLAGS_RST;
            s_q.irq_sel <= isf_pkg::SRC_NONE;
            s_q.state <= isf_pkg::ISF_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign ext_irq_a_flag = s_q.ext_irq_a_flag;
    assign ext_irq_b_flag = s_q.ext_irq_b_flag;
    assign timer_zero_overflow_flag = s_q.timer_zero_overflow_flag;
    assign timer_one_overflow_flag = s_q.timer_one_overflow_flag;
    assign timer_two_overflow_flag = s_q.timer_two_overflow_flag;
    assign timer_two_ext_flag = s_q.timer_two_ext_flag;
    assign serial_ctrl_irq_flag = s_q.serial_ctrl_irq_flag;
    assign ddc2b_flag = s_q.ddc2b_flag;
    assign ddc1_flag = s_q.ddc1_flag;
    assign protocol_switch_flag = s_q.protocol_switch_flag;
    assign usb_flags = s_q.usb_flags;
    assign src_req = s_q.src_req;
    assign irq_req = s_q.irq_req;
    assign irq_sel = s_q.irq_sel;

    // ************************************************************
    // checks
    // ************************************************************
    AST_T2_NO_HW_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        $fell(timer_two_overflow_flag) |-> $past(timer_two_sw_clear))
        else $error("timer two flag cleared without software");
    AST_T0_SET: assert property (@(posedge mclk) disable iff (rst)
        timer_zero_overflow && timer_zero_mode != isf_pkg::TMR0_MODE_SPLIT
        |=> timer_zero_overflow_flag)
        else $error("timer zero overflow lost");
    AST_T0_MODE3: assert property (@(posedge mclk) disable iff (rst)
        !timer_zero_overflow_flag && timer_zero_mode == isf_pkg::TMR0_MODE_SPLIT
        |=> !timer_zero_overflow_flag)
        else $error("timer zero flag set in split mode");
    AST_T1_CLR: assert property (@(posedge mclk) disable iff (rst)
        $fell(timer_one_overflow_flag) |-> $past(core_vector))
        else $error("timer one flag cleared without service");
    AST_USB_HOLD: assert property (@(posedge mclk) disable iff (rst)
        usb_flags[0] && !usb_sw_clear[0] |=> usb_flags[0])
        else $error("usb flag dropped without software clear");
    AST_USB_SET: assert property (@(posedge mclk) disable iff (rst)
        usb_events[0] |=> usb_flags[0] && src_req[isf_pkg::SRC_USB])
        else $error("usb event did not reach request");
    AST_GLOBAL_OFF: assert property (@(posedge mclk) disable iff (rst)
        !global_irq_enable |=> !irq_req)
        else $error("request while globally disabled");
    AST_DDC1_HOLD: assert property (@(posedge mclk) disable iff (rst)
        ddc1_flag && !ddc_sw_clear |=> ddc1_flag)
        else $error("ddc1 flag cleared by hardware");
    AST_POLL_FIRST: assert property (@(posedge mclk) disable iff (rst)
        irq_req && src_req[isf_pkg::SRC_EXT_A] && src_enable[0]
        && $stable(src_enable) && global_irq_enable && $stable(src_req)
        && $past(s_q.state) == isf_pkg::ISF_IDLE && !$past(core_vector)
        |-> irq_sel == 4'h0)
        else $error("polling order not honoured");
    AST_EXTA_LEVEL: assert property (@(posedge mclk) disable iff (rst)
        !ext_irq_a_trigger_type && !s_q.sync_a[1] |=> ext_irq_a_flag)
        else $error("level flag dropped while pin active");
endmodule : isf_top

// ### hdl/isf_pkg.sv
// Purpose: shared constants and types for the interrupt source flag block
// Assumes: one clock, synchronous active-high reset
// Notes: source index order is the fixed polling order, 0 polled first
package isf_pkg;
    localparam int unsigned NUM_SRC = 10;
    // source indices in polling order
    localparam int unsigned SRC_EXT_A = 0;
    localparam int unsigned SRC_UART_B = 1;
    localparam int unsigned SRC_TMR0 = 2;
    localparam int unsigned SRC_TWI = 3;
    localparam int unsigned SRC_EXT_B = 4;
    localparam int unsigned SRC_DDC = 5;
    localparam int unsigned SRC_TMR1 = 6;
    localparam int unsigned SRC_USB = 7;
    localparam int unsigned SRC_UART_A = 8;
    localparam int unsigned SRC_TMR2 = 9;
    localparam logic [3:0] SRC_NONE = 4'hf;
    localparam logic [1:0] TMR0_MODE_SPLIT = 2'h3;
    localparam logic [6:0] USB_FLAGS_RST = 7'h00;

    typedef enum logic [1:0] {
        ISF_IDLE = 2'b00,
        ISF_ACK = 2'b01
    } isf_state_t;

    typedef struct packed {
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        logic [1:0] sync_timer_two_ext_input;
        logic ext_a_prev;
        logic ext_b_prev;
        logic timer_two_ext_input_prev;
        logic ext_irq_a_flag;
        logic ext_irq_b_flag;
        logic timer_zero_overflow_flag;
        logic timer_one_overflow_flag;
        logic timer_two_overflow_flag;
        logic timer_two_ext_flag;
        logic serial_ctrl_irq_flag;
        logic ddc2b_flag;
        logic ddc1_flag;
        logic protocol_switch_flag;
        logic [6:0] usb_flags;
        logic [NUM_SRC-1:0] src_req;
        logic irq_req;
        logic [3:0] irq_sel;
        isf_state_t state;
    } isf_state_s_t;
endpackage : isf_pkg

// ### testbench/isf_core_model.sv
// Purpose: core side model that takes the currently selected interrupt
// Assumes: block outputs settle after the rising edge of mclk
// Notes: acks are one-cycle pulses, at least two cycles apart
`timescale 1ns/1ps
module isf_core_model (
    input wire logic mclk,
    input wire logic en,
    input wire logic irq_req,
    output logic core_vector
);
    logic gap = 1'b0;
    logic en_q = 1'b0;
    // ****************************************
    // vectoring
    // ****************************************
    // en taken on the rising edge so a falling-edge bench change cannot race
    always @(posedge mclk) begin
        en_q <= en;
    end
    // two gap cycles after each ack, as a real core needs time to stack
    always @(negedge mclk) begin
        gap <= core_vector;
        core_vector <= en_q && irq_req && !core_vector && !gap;
    end
endmodule : isf_core_model

// ### testbench/tb_interrupt_source_flags.sv
// Purpose: self-checking bench for the interrupt source flag block
// Assumes: inputs driven on falling edge, outputs checked there too
// Notes: random rounds use seed 61; pins idle high
`timescale 1ns/1ps
module tb_interrupt_source_flags;
    logic mclk, rst, ext_irq_a_pin, ext_irq_b_pin, adc_owns_ext_b, adc_done;
    logic ext_irq_a_trigger_type, ext_irq_b_trigger_type, core_en;
    logic [1:0] timer_zero_mode;
    logic timer_zero_overflow, timer_one_overflow, timer_two_overflow;
    logic timer_two_ext_input, timer_two_ext_enable, timer_two_sw_clear;
    logic twowire_event, ddc2b_event, ddc1_event, protocol_switch_event;
    logic ddc_sw_clear, uart_a_req, uart_b_req, global_irq_enable;
    logic core_vector, irq_req, ext_irq_a_flag, ext_irq_b_flag, ddc2b_flag;
    logic timer_zero_overflow_flag, timer_one_overflow_flag, ddc1_flag;
    logic timer_two_overflow_flag, timer_two_ext_flag, serial_ctrl_irq_flag;
    logic protocol_switch_flag;
    logic [6:0] usb_events, usb_sw_clear, usb_flags, u;
    logic [9:0] src_enable, src_req, ev, m;
    logic [3:0] irq_sel;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 61;

    isf_top uut (.mclk, .rst, .ext_irq_a_pin, .ext_irq_b_pin,
        .ext_irq_a_trigger_type, .ext_irq_b_trigger_type, .adc_owns_ext_b,
        .adc_done, .timer_zero_mode, .timer_zero_overflow, .timer_one_overflow,
        .timer_two_overflow, .timer_two_ext_input, .timer_two_ext_enable,
        .timer_two_sw_clear, .twowire_event, .ddc2b_event, .ddc1_event,
        .protocol_switch_event, .ddc_sw_clear, .usb_events, .usb_sw_clear,
        .uart_a_req, .uart_b_req, .src_enable, .global_irq_enable,
        .core_vector, .ext_irq_a_flag, .ext_irq_b_flag,
        .timer_zero_overflow_flag, .timer_one_overflow_flag,
        .timer_two_overflow_flag, .timer_two_ext_flag, .serial_ctrl_irq_flag,
        .ddc2b_flag, .ddc1_flag, .protocol_switch_flag, .usb_flags, .src_req,
        .irq_req, .irq_sel);
    isf_core_model core (.mclk(mclk), .en(core_en), .irq_req(irq_req),
        .core_vector(core_vector));

    // ****************************************
    // helpers
    // ****************************************
    task automatic cmp(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic idle;
        {timer_zero_overflow, timer_one_overflow, timer_two_overflow} = '0;
        {twowire_event, ddc2b_event, ddc1_event, protocol_switch_event} = '0;
        {timer_two_sw_clear, ddc_sw_clear} = '0;
        usb_events = '0;
        usb_sw_clear = '0;
    endtask : idle
    task automatic sw_clear;
        {timer_two_sw_clear, ddc_sw_clear} = 2'h3;
        usb_sw_clear = 7'h7f;
        cyc(1);
        idle();
        cyc(1);
    endtask : sw_clear
    // lowest enabled index wins, none when globally disabled
    function automatic logic [3:0] exp_sel(input logic [9:0] r,
        input logic [9:0] e, input logic g);
        exp_sel = 4'hf;
        for (int i = 9; i >= 0; i--) begin
            if (g && r[i] && e[i]) exp_sel = 4'(i);
        end
    endfunction : exp_sel
    task automatic ext_case(input logic b, input logic trig);
        core_en = 1'b0;
        ext_irq_a_trigger_type = trig;
        ext_irq_b_trigger_type = trig;
        if (b) ext_irq_b_pin = 1'b0;
        else ext_irq_a_pin = 1'b0;
        cyc(5);
        if (trig) {ext_irq_a_pin, ext_irq_b_pin} = 2'h3;
        cyc(4);
        cmp(b ? ext_irq_b_flag : ext_irq_a_flag, 10'h1);
        core_en = 1'b1;
        cyc(6);
        cmp(b ? ext_irq_b_flag : ext_irq_a_flag, {9'h0, !trig});
        {ext_irq_a_pin, ext_irq_b_pin} = 2'h3;
        cyc(6);
        cmp(src_req[b ? 4 : 0], 10'h0);
    endtask : ext_case
    task automatic end_of_test;
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // ****************************************
    // clock, watchdog and sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        idle();
        {ext_irq_a_pin, ext_irq_b_pin, timer_two_ext_input} = 3'h7;
        {ext_irq_a_trigger_type, ext_irq_b_trigger_type} = '0;
        {adc_owns_ext_b, adc_done, timer_two_ext_enable, core_en} = '0;
        {uart_a_req, uart_b_req} = '0;
        timer_zero_mode = 2'h0;
        src_enable = 10'h3ff;
        global_irq_enable = 1'b1;
        cyc(20);
        rst = 1'b0;
        cyc(1);
        cmp(irq_sel, 10'hf);
        for (int i = 0; i < 4; i++) ext_case(i[1], i[0]);
        // converter completion routed onto the second external line
        core_en = 1'b0;
        ext_irq_b_trigger_type = 1'b1;
        adc_owns_ext_b = 1'b1;
        adc_done = 1'b1;
        cyc(2);
        adc_done = 1'b0;
        cyc(6);
        cmp(ext_irq_b_flag, 10'h1);
        adc_owns_ext_b = 1'b0;
        cyc(4);
        core_en = 1'b1;
        cyc(6);
        // timer two external pin, first gated off then on
        timer_two_ext_input = 1'b0;
        cyc(6);
        cmp(timer_two_ext_flag, 10'h0);
        timer_two_ext_input = 1'b1;
        timer_two_ext_enable = 1'b1;
        cyc(4);
        timer_two_ext_input = 1'b0;
        cyc(8);
        cmp(src_req, 10'h200);
        timer_two_ext_input = 1'b1;
        sw_clear();
        repeat (20) begin
            core_en = 1'b0;
            src_enable = 10'($random(seed));
            global_irq_enable = 1'($random(seed));
            timer_zero_mode = 2'($random(seed));
            ev = 10'($random(seed));
            u = 7'($random(seed));
            {timer_zero_overflow, timer_one_overflow, timer_two_overflow} = ev[2:0];
            {twowire_event, ddc2b_event, ddc1_event} = ev[5:3];
            {protocol_switch_event, uart_a_req, uart_b_req} = ev[8:6];
            usb_events = u;
            // src_req bit 9 down to 0, in polling index order
            m = {ev[0], ev[7], |u, ev[1], ev[4] | ev[3] | ev[8], 1'b0, ev[5],
                ev[2] && timer_zero_mode != 2'h3, ev[6], 1'b0};
            cyc(1);
            idle();
            cmp(src_req, m);
            cmp({timer_zero_overflow_flag, timer_one_overflow_flag,
                timer_two_overflow_flag, timer_two_ext_flag,
                serial_ctrl_irq_flag, ddc2b_flag, ddc1_flag,
                protocol_switch_flag}, {ev[2] && timer_zero_mode != 2'h3,
                ev[1:0], 1'b0, ev[5:3], ev[8]});
            cmp(irq_sel, exp_sel(m, src_enable, global_irq_enable));
            cmp(irq_req, |(m & src_enable) & global_irq_enable);
            {uart_a_req, uart_b_req} = '0;
            // keep sticky sources disabled so the rest get serviced
            src_enable = 10'h15f;
            global_irq_enable = 1'b1;
            core_en = 1'b1;
            cyc(30);
            cmp(src_req, m & 10'h2a0);
            cmp(usb_flags, u);
            sw_clear();
            // ddc2b has no software clear, so let the core service it
            src_enable = 10'h3ff;
            cyc(8);
            cmp(src_req, 10'h0);
        end
        end_of_test();
    end
endmodule : tb_interrupt_source_flags
